// file: flash_sec_pkg.sv
// Overview of operation
// - Backdoor key is four 16-bit words read from the configuration field.
// - Key-verify compares four software keys with stored words when key access enabled.
// - All four keys matching sets the security state field to unsecured.
// - Stored key words of all zeros or all ones never match.
// - Array reads are flagged invalid while key-verify executes.
// - Every reset loads keys, both protection registers, option and security registers.
// - Faults during reset load leave everything protected and the device secured.
// - A double-bit fault during reset load sets both verify status bits.
// - Complete flag low during reset load, high at its end; commands accepted after.
// - Bus accesses stall during the load; reads allowed once the stall ends.
// - Reset during any command aborts it at once; target contents undefined.
// - Sector erase flags access error unless index pointer equals 001 at launch.
// - Commands not permitted in the present mode flag access error.
// - Sector erase flags access error when address bits 2:0 are nonzero.
// - Sector erase flags access error when address bits 17:16 select no region.
// - Sector erase on protected program flash flags protection violation, no erase.
// - Verify sets any-error bit on any error, uncorrectable bit on uncorrectable ones.
// - Unsecure 0x0B, index 000, erases and verifies all; releases security on success.
// - Failed unsecure verify sets any-error bit and leaves security unchanged.
// - Unsecure flags protection violation if any program flash or EEPROM is protected.
// - Option register loads at reset; double-bit fault forces all its bits to one.
// - Both reserved test registers read zero and ignore writes.
// - After a key mismatch, later key-verify attempts flag access error until reset.
// - Key-verify uses code 0x0C, index 100, keys 0 to 3 in successive words.
package flash_sec_pkg;
  // ==========================================================================
  // Register byte offsets.
  localparam logic [5:0] OFS_STATUS = 6'h00;
  localparam logic [5:0] OFS_INDEX = 6'h04;
  localparam logic [5:0] OFS_COBJ = 6'h08;
  localparam logic [5:0] OFS_SEC = 6'h0C;
  localparam logic [5:0] OFS_PPROT = 6'h10;
  localparam logic [5:0] OFS_EPROT = 6'h14;
  localparam logic [5:0] OFS_OPT = 6'h18;
  localparam logic [5:0] OFS_RSV_A = 6'h1C;
  localparam logic [5:0] OFS_RSV_B = 6'h20;
  // ==========================================================================
  // Field positions and values.
  localparam int BIT_DONE = 7;
  localparam int BIT_ACC_ERR = 5;
  localparam int BIT_VIOL = 4;
  localparam int BIT_MG_ANY = 1;
  localparam int BIT_MG_UNC = 0;
  localparam int BIT_PROT_OPEN = 7;
  localparam logic [1:0] KEY_EN_ON = 2'h2;
  localparam logic [1:0] SEC_UNSECURED = 2'h2;
  localparam logic [7:0] SEC_DEFAULT = 8'hFF;
  localparam logic [7:0] PROT_DEFAULT = 8'h00;
  localparam logic [7:0] OPT_FAULT = 8'hFF;
  localparam logic [15:0] KEY_ZERO = 16'h0000;
  localparam logic [15:0] KEY_ONES = 16'hFFFF;
  // ==========================================================================
  // Commands, index values and configuration addresses.
  localparam logic [7:0] CMD_ERASE_SECTOR = 8'h0A;
  localparam logic [7:0] CMD_UNSECURE = 8'h0B;
  localparam logic [7:0] CMD_VERIFY_KEY = 8'h0C;
  localparam logic [2:0] IDX_ERASE = 3'h1;
  localparam logic [2:0] IDX_UNSECURE = 3'h0;
  localparam logic [2:0] IDX_KEY = 3'h4;
  localparam logic [2:0] IDX_MAX = 3'h4;
  localparam logic [1:0] PF_HI_VALID = 2'h3;
  localparam logic [17:0] CFG_KEY_BASE = 18'h3_FF00;
  localparam logic [17:0] CFG_PROT_ADDR = 18'h3_FF0C;
  localparam logic [17:0] CFG_OPTSEC_ADDR = 18'h3_FF0E;
  localparam logic [2:0] CFG_WORD_PROT = 3'h4;
  localparam logic [2:0] CFG_WORD_LAST = 3'h5;
  // Array operation codes on the array port.
  localparam logic [2:0] NVM_READ = 3'h0;
  localparam logic [2:0] NVM_ERASE_SECTOR = 3'h1;
  localparam logic [2:0] NVM_ERASE_ALL = 3'h2;
  localparam logic [2:0] NVM_VERIFY_SECTOR = 3'h3;
  localparam logic [2:0] NVM_VERIFY_ALL = 3'h4;
endpackage

// file: launch_check_if.sv
`timescale 1ns/10ps
// Signals shared by the sequencer and its two launch checkers.
interface launch_check_if;
  logic [15:0] stored_key [4];
  logic [15:0] cand_key [4];
  logic key_match;
  logic [7:0] cmd_code;
  logic [2:0] cmd_index;
  logic [17:0] erase_addr;
  logic cmd_permitted;
  logic pflash_open;
  logic eeprom_open;
  logic [1:0] key_enable_field;
  logic key_locked;
  logic check_acc_err;
  logic check_viol;
  modport seq (output stored_key, cand_key, cmd_code, cmd_index, erase_addr, cmd_permitted,
               pflash_open, eeprom_open, key_enable_field, key_locked,
               input key_match, check_acc_err, check_viol);
  modport keycmp (input stored_key, cand_key, output key_match);
  modport cmdchk (input cmd_code, cmd_index, erase_addr, cmd_permitted, pflash_open,
                  eeprom_open, key_enable_field, key_locked, output check_acc_err, check_viol);
endinterface

// file: backdoor_key_compare.sv
`timescale 1ns/10ps
// Compares the four candidate keys with the stored backdoor words.
module backdoor_key_compare (
  launch_check_if.keycmp chk
);
  logic [3:0] word_ok;
  // A stored word of all zeros or all ones is unprogrammed or blank, so it never counts.
  for (genvar i = 0; i < 4; i++) begin : g_key
    assign word_ok[i] = (chk.cand_key[i] == chk.stored_key[i]) &&
                        (chk.stored_key[i] != flash_sec_pkg::KEY_ZERO) &&
                        (chk.stored_key[i] != flash_sec_pkg::KEY_ONES);
  end
  assign chk.key_match = &word_ok;
endmodule

// file: cmd_launch_check.sv
`timescale 1ns/10ps
// Decides at launch whether a command is refused, and with which flag.
module cmd_launch_check (
  launch_check_if.cmdchk chk
);
  logic is_erase;
  logic is_unsec;
  logic is_key;
  logic erase_bad;
  logic unsec_bad;
  logic key_bad;
  assign is_erase = chk.cmd_code == flash_sec_pkg::CMD_ERASE_SECTOR;
  assign is_unsec = chk.cmd_code == flash_sec_pkg::CMD_UNSECURE;
  assign is_key = chk.cmd_code == flash_sec_pkg::CMD_VERIFY_KEY;
  // Sector erase needs index 001, a phrase aligned address and a valid upper region.
  assign erase_bad = (chk.cmd_index != flash_sec_pkg::IDX_ERASE) ||
                     (chk.erase_addr[2:0] != 3'h0) ||
                     (chk.erase_addr[17:16] != flash_sec_pkg::PF_HI_VALID);
  assign unsec_bad = chk.cmd_index != flash_sec_pkg::IDX_UNSECURE;
  // A key mismatch since reset locks out every later attempt.
  assign key_bad = (chk.cmd_index != flash_sec_pkg::IDX_KEY) ||
                   (chk.key_enable_field != flash_sec_pkg::KEY_EN_ON) ||
                   chk.key_locked;
  // Unknown codes are refused too, since this block runs no other command.
  assign chk.check_acc_err = !chk.cmd_permitted ||
                            (is_erase && erase_bad) || (is_unsec && unsec_bad) ||
                            (is_key && key_bad) || !(is_erase || is_unsec || is_key);
  assign chk.check_viol = (is_erase && !chk.pflash_open) ||
                            (is_unsec && (!chk.pflash_open || !chk.eeprom_open));
endmodule

// file: flash_security_init_control.sv
`timescale 1ns/10ps
// Flash security, reset load and command sequencer with an Avalon-MM register slave.
module flash_security_init_control (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic nvm_req,
  output logic [2:0] nvm_op,
  output logic [17:0] nvm_addr,
  input wire logic nvm_ack,
  input wire logic [15:0] nvm_rdata,
  input wire logic nvm_sbe,
  input wire logic nvm_dbe,
  input wire logic cmd_permitted,
  output logic array_read_valid,
  output logic device_secured
);
  // ==========================================================================
  // State and storage.
  typedef enum logic [2:0] {
    ST_INIT_RD,
    ST_INIT_FIN,
    ST_IDLE,
    ST_CHECK,
    ST_ERASE,
    ST_VERIFY,
    ST_DONE
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [2:0] init_idx_reg;
  logic [2:0] init_idx_next;
  logic init_fault_reg;
  logic done_reg;
  logic done_next;
  logic acc_err_reg;
  logic viol_reg;
  logic [1:0] mg_reg;
  logic [1:0] mg_next;
  logic acc_set;
  logic fpv_set;
  logic [2:0] index_reg;
  logic [15:0] cobj_reg [5];
  logic [15:0] key_reg [4];
  logic [7:0] sec_reg;
  logic [7:0] sec_next;
  logic [7:0] pprot_reg;
  logic [7:0] eprot_reg;
  logic [7:0] opt_reg;
  logic key_locked_reg;
  logic lock_set;
  logic nvm_req_reg;
  logic nvm_req_next;
  logic [2:0] nvm_op_reg;
  logic [2:0] nvm_op_next;
  logic [17:0] nvm_addr_reg;
  logic [17:0] nvm_addr_next;
  logic rd_ready_reg;
  logic [31:0] readdata_reg;
  logic unsec_cmd_reg;
  logic unsec_cmd_next;

  launch_check_if chk ();

  backdoor_key_compare u_key (
    .chk(chk)
  );

  cmd_launch_check u_check (
    .chk(chk)
  );

  // ==========================================================================
  // Bus decode.
  // Any access waits while the configuration reads run.
  wire stall = state_reg == ST_INIT_RD;
  wire wr_hit = write && !stall;
  wire sel_status = address == flash_sec_pkg::OFS_STATUS;
  wire sel_index = address == flash_sec_pkg::OFS_INDEX;
  wire sel_cobj = address == flash_sec_pkg::OFS_COBJ;
  wire sel_sec = address == flash_sec_pkg::OFS_SEC;
  wire sel_pprot = address == flash_sec_pkg::OFS_PPROT;
  wire sel_eprot = address == flash_sec_pkg::OFS_EPROT;
  wire sel_opt = address == flash_sec_pkg::OFS_OPT;
  wire status_wr = wr_hit && sel_status && byteenable[0];
  wire clr_acc = status_wr && writedata[flash_sec_pkg::BIT_ACC_ERR];
  wire clr_fpv = status_wr && writedata[flash_sec_pkg::BIT_VIOL];
  // A launch is ignored while an old error flag is still standing.
  wire launch = status_wr && writedata[flash_sec_pkg::BIT_DONE] && done_reg &&
                !acc_err_reg && !viol_reg && state_reg == ST_IDLE;
  // Command setup registers are frozen while a command runs.
  wire idx_wr = wr_hit && sel_index && byteenable[0] && done_reg;
  wire cobj_wr = wr_hit && sel_cobj && done_reg && index_reg <= flash_sec_pkg::IDX_MAX;
  wire [7:0] status_byte = {done_reg, 1'b0, acc_err_reg, viol_reg, 2'b00, mg_reg};

  // Reserved test registers read zero like unmapped words.
  wire [7:0] rd_byte = sel_status ? status_byte :
                       sel_index ? {5'h00, index_reg} :
                       sel_sec ? sec_reg :
                       sel_pprot ? pprot_reg :
                       sel_eprot ? eprot_reg :
                       sel_opt ? opt_reg : 8'h00;
  wire [31:0] rd_mux = sel_cobj ? {16'h0000, cobj_reg[index_reg <= flash_sec_pkg::IDX_MAX ?
                       index_reg : 3'h0]} : {24'h00_0000, rd_byte};

  // Reads take one wait cycle so that data leave a flip-flop.
  assign waitrequest = (stall && (read || write)) || (read && !rd_ready_reg);
  assign readdata = readdata_reg;

  // ==========================================================================
  // Launch check inputs.
  for (genvar i = 0; i < 4; i++) begin : g_keys
    assign chk.stored_key[i] = key_reg[i];
    assign chk.cand_key[i] = cobj_reg[i + 1];
  end
  assign chk.cmd_code = cobj_reg[0][15:8];
  assign chk.cmd_index = index_reg;
  assign chk.erase_addr = {cobj_reg[0][1:0], cobj_reg[1]};
  assign chk.cmd_permitted = cmd_permitted;
  assign chk.pflash_open = pprot_reg[flash_sec_pkg::BIT_PROT_OPEN];
  assign chk.eeprom_open = eprot_reg[flash_sec_pkg::BIT_PROT_OPEN];
  assign chk.key_enable_field = sec_reg[7:6];
  assign chk.key_locked = key_locked_reg;

  wire is_key_cmd = cobj_reg[0][15:8] == flash_sec_pkg::CMD_VERIFY_KEY;
  // Array data are not trustworthy while the key comparison runs.
  assign array_read_valid = !(state_reg == ST_CHECK && is_key_cmd) && !stall;
  assign device_secured = sec_reg[1:0] != flash_sec_pkg::SEC_UNSECURED;
  assign nvm_req = nvm_req_reg;
  assign nvm_op = nvm_op_reg;
  assign nvm_addr = nvm_addr_reg;

  // Configuration word address for each step of the reset load.
  wire [17:0] cfg_addr = (init_idx_reg < flash_sec_pkg::CFG_WORD_PROT) ?
                         flash_sec_pkg::CFG_KEY_BASE + {14'h0000, init_idx_reg, 1'b0} :
                         (init_idx_reg == flash_sec_pkg::CFG_WORD_PROT) ?
                         flash_sec_pkg::CFG_PROT_ADDR : flash_sec_pkg::CFG_OPTSEC_ADDR;
  wire init_take = state_reg == ST_INIT_RD && nvm_ack;
  wire verify_fail = nvm_sbe || nvm_dbe;

  // ==========================================================================
  // Sequencer.
  // Reset load first, then one command at a time.
  always_comb begin
    state_next = state_reg;
    init_idx_next = init_idx_reg;
    done_next = done_reg;
    mg_next = mg_reg;
    sec_next = sec_reg;
    acc_set = 1'b0;
    fpv_set = 1'b0;
    lock_set = 1'b0;
    nvm_req_next = nvm_req_reg;
    nvm_op_next = nvm_op_reg;
    nvm_addr_next = nvm_addr_reg;
    unsec_cmd_next = unsec_cmd_reg;
    unique case (state_reg)
      ST_INIT_RD: begin
        if (!nvm_req_reg) begin
          nvm_req_next = 1'b1;
          nvm_op_next = flash_sec_pkg::NVM_READ;
          nvm_addr_next = cfg_addr;
        end else if (nvm_ack) begin
          nvm_req_next = 1'b0;
          if (nvm_dbe) begin
            mg_next = 2'b11;
          end
          if (init_idx_reg == flash_sec_pkg::CFG_WORD_LAST) begin
            state_next = ST_INIT_FIN;
          end else begin
            init_idx_next = init_idx_reg + 3'h1;
          end
        end
      end
      ST_INIT_FIN: begin
        done_next = 1'b1;
        state_next = ST_IDLE;
      end
      ST_IDLE: begin
        if (launch) begin
          done_next = 1'b0;
          mg_next = 2'b00;
          state_next = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (chk.check_acc_err) begin
          acc_set = 1'b1;
          state_next = ST_DONE;
        end else if (chk.check_viol) begin
          fpv_set = 1'b1;
          state_next = ST_DONE;
        end else if (is_key_cmd) begin
          if (chk.key_match) begin
            sec_next = {sec_reg[7:2], flash_sec_pkg::SEC_UNSECURED};
          end else begin
            acc_set = 1'b1;
            lock_set = 1'b1;
          end
          state_next = ST_DONE;
        end else begin
          unsec_cmd_next = cobj_reg[0][15:8] == flash_sec_pkg::CMD_UNSECURE;
          nvm_req_next = 1'b1;
          nvm_op_next = (cobj_reg[0][15:8] == flash_sec_pkg::CMD_UNSECURE) ?
                        flash_sec_pkg::NVM_ERASE_ALL : flash_sec_pkg::NVM_ERASE_SECTOR;
          nvm_addr_next = chk.erase_addr;
          state_next = ST_ERASE;
        end
      end
      ST_ERASE: begin
        if (nvm_ack) begin
          nvm_req_next = 1'b0;
          state_next = ST_VERIFY;
        end
      end
      ST_VERIFY: begin
        if (!nvm_req_reg) begin
          nvm_req_next = 1'b1;
          nvm_op_next = unsec_cmd_reg ? flash_sec_pkg::NVM_VERIFY_ALL :
                        flash_sec_pkg::NVM_VERIFY_SECTOR;
        end else if (nvm_ack) begin
          nvm_req_next = 1'b0;
          mg_next = {verify_fail, nvm_dbe};
          if (unsec_cmd_reg && !verify_fail) begin
            sec_next = {sec_reg[7:2], flash_sec_pkg::SEC_UNSECURED};
          end
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        done_next = 1'b1;
        state_next = ST_IDLE;
      end
    endcase
    // A failed reset load falls back to the protected, secured defaults.
    if (state_reg == ST_INIT_FIN && init_fault_reg) begin
      sec_next = flash_sec_pkg::SEC_DEFAULT;
    end
  end

  // ==========================================================================
  // Control registers.
  // Reset abandons any command at once; the array sees its request drop.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_INIT_RD;
      init_idx_reg <= 3'h0;
      done_reg <= 1'b0;
      nvm_req_reg <= 1'b0;
      nvm_op_reg <= flash_sec_pkg::NVM_READ;
      nvm_addr_reg <= 18'h0_0000;
      unsec_cmd_reg <= 1'b0;
      mg_reg <= 2'b00;
    end else begin
      state_reg <= state_next;
      init_idx_reg <= init_idx_next;
      done_reg <= done_next;
      nvm_req_reg <= nvm_req_next;
      nvm_op_reg <= nvm_op_next;
      nvm_addr_reg <= nvm_addr_next;
      unsec_cmd_reg <= unsec_cmd_next;
      mg_reg <= mg_next;
    end
  end

  // Error flags: a hardware set in the clearing cycle wins.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      acc_err_reg <= 1'b0;
      viol_reg <= 1'b0;
      key_locked_reg <= 1'b0;
    end else begin
      acc_err_reg <= (acc_err_reg && !clr_acc) || acc_set;
      viol_reg <= (viol_reg && !clr_fpv) || fpv_set;
      key_locked_reg <= key_locked_reg || lock_set;
    end
  end

  // Configuration registers loaded from the array during the reset load.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sec_reg <= flash_sec_pkg::SEC_DEFAULT;
      pprot_reg <= flash_sec_pkg::PROT_DEFAULT;
      eprot_reg <= flash_sec_pkg::PROT_DEFAULT;
      opt_reg <= flash_sec_pkg::OPT_FAULT;
      init_fault_reg <= 1'b0;
    end else if (init_take && init_idx_reg == flash_sec_pkg::CFG_WORD_PROT) begin
      pprot_reg <= nvm_dbe ? flash_sec_pkg::PROT_DEFAULT : nvm_rdata[15:8];
      eprot_reg <= nvm_dbe ? flash_sec_pkg::PROT_DEFAULT : nvm_rdata[7:0];
      init_fault_reg <= init_fault_reg || nvm_dbe;
    end else if (init_take && init_idx_reg == flash_sec_pkg::CFG_WORD_LAST) begin
      opt_reg <= nvm_dbe ? flash_sec_pkg::OPT_FAULT : nvm_rdata[15:8];
      sec_reg <= nvm_dbe ? flash_sec_pkg::SEC_DEFAULT : nvm_rdata[7:0];
      init_fault_reg <= init_fault_reg || nvm_dbe;
    end else if (init_take) begin
      init_fault_reg <= init_fault_reg || nvm_dbe;
    end else if (state_reg == ST_INIT_FIN && init_fault_reg) begin
      pprot_reg <= flash_sec_pkg::PROT_DEFAULT;
      eprot_reg <= flash_sec_pkg::PROT_DEFAULT;
      sec_reg <= sec_next;
    end else begin
      sec_reg <= sec_next;
    end
  end

  // Backdoor key words; a faulted word is zeroed so it can never match.
  for (genvar i = 0; i < 4; i++) begin : g_keyload
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        key_reg[i] <= flash_sec_pkg::KEY_ZERO;
      end else if (init_take && init_idx_reg == 3'(i)) begin
        key_reg[i] <= nvm_dbe ? flash_sec_pkg::KEY_ZERO : nvm_rdata;
      end
    end
  end

  // ==========================================================================
  // Command setup registers.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      index_reg <= 3'h0;
    end else if (idx_wr) begin
      index_reg <= writedata[2:0];
    end
  end

  // Each command object word is written byte by byte at the current index.
  for (genvar i = 0; i < 5; i++) begin : g_cobj
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        cobj_reg[i] <= 16'h0000;
      end else if (cobj_wr && index_reg == 3'(i)) begin
        cobj_reg[i][7:0] <= byteenable[0] ? writedata[7:0] : cobj_reg[i][7:0];
        cobj_reg[i][15:8] <= byteenable[1] ? writedata[15:8] : cobj_reg[i][15:8];
      end
    end
  end

  // ==========================================================================
  // Read data path.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_ready_reg <= 1'b0;
      readdata_reg <= 32'h0000_0000;
    end else begin
      rd_ready_reg <= read && !stall && !rd_ready_reg;
      if (read && !stall && !rd_ready_reg) begin
        readdata_reg <= rd_mux;
      end
    end
  end
endmodule

// file: nvm_array_model.sv
`timescale 1ns/10ps
// ==========
// Array model: a one-cycle acknowledge per request, fast or slow by address.
module nvm_array_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic nvm_req,
  input wire logic [2:0] nvm_op,
  input wire logic [17:0] nvm_addr,
  input wire logic [17:0] fault_addr,
  input wire logic fault_verify,
  output logic nvm_ack,
  output logic [15:0] nvm_rdata,
  output logic nvm_sbe,
  output logic nvm_dbe
);
  logic [1:0] wait_reg;
  logic [15:0] word;
  // Configuration words; no key word is all zeros or all ones.
  always_comb begin
    case (nvm_addr)
      18'h3_FF00: word = 16'h1111;
      18'h3_FF02: word = 16'h2222;
      18'h3_FF04: word = 16'h3333;
      18'h3_FF06: word = 16'h4444;
      18'h3_FF0C: word = 16'h8080;
      18'h3_FF0E: word = 16'h5A83;
      default: word = 16'h0000;
    endcase
  end
  // Odd word addresses answer at once; the rest wait three cycles.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      nvm_ack <= 1'b0;
      wait_reg <= 2'h0;
    end else if (nvm_req && !nvm_ack && wait_reg == (nvm_addr[1] ? 2'h0 : 2'h3)) begin
      nvm_ack <= 1'b1;
      wait_reg <= 2'h0;
    end else begin
      nvm_ack <= 1'b0;
      wait_reg <= (nvm_req && !nvm_ack) ? wait_reg + 2'h1 : 2'h0;
    end
  end
  // Data are inverted outside an acknowledge so stale words cannot pass as answers.
  assign nvm_rdata = nvm_ack ? word : ~word;
  assign nvm_dbe = nvm_ack && (nvm_addr == fault_addr || (fault_verify && nvm_op >= 3'h3));
  assign nvm_sbe = nvm_dbe;
endmodule

// file: flash_sec_assertions.sv
`timescale 1ns/10ps
// ==========
// Port checks; the reset-time ones cannot use reset as their disable.
module flash_sec_assertions (
  input wire logic clock,
  input wire logic nrst,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic nvm_req,
  input wire logic [2:0] nvm_op,
  input wire logic [17:0] nvm_addr,
  input wire logic nvm_ack,
  input wire logic array_read_valid,
  input wire logic device_secured
);
  a_reset_aborts: assert property (@(posedge clock) !nrst |-> !nvm_req)
    else $error("array request during reset");
  a_reset_secured: assert property (@(posedge clock) !nrst |-> device_secured)
    else $error("not secured in reset");
  a_reset_stalls: assert property (@(posedge clock) !nrst |-> waitrequest == (read || write))
    else $error("access not stalled in reset");
  a_load_first_key: assert property (@(posedge clock) disable iff (!nrst)
    $rose(nrst) |-> ##[0:2] (nvm_req && nvm_op == 3'h0 && nvm_addr == 18'h3_FF00))
    else $error("load does not start at key word");
  a_load_stays_secure: assert property (@(posedge clock) disable iff (!nrst)
    $rose(nrst) |-> device_secured [*8]) else $error("released early in load");
  a_stall_reads_only: assert property (@(posedge clock) disable iff (!nrst)
    write && waitrequest && nvm_req |-> nvm_op == 3'h0) else $error("non-read op in load");
  a_stall_no_valid: assert property (@(posedge clock) disable iff (!nrst)
    write && waitrequest |-> !array_read_valid) else $error("reads valid during stall");
  a_sector_verify: assert property (@(posedge clock) disable iff (!nrst)
    nvm_ack && nvm_op == 3'h1 |-> ##[1:4] (nvm_req && nvm_op == 3'h3)) else $error("no sector verify");
  a_all_verify: assert property (@(posedge clock) disable iff (!nrst)
    nvm_ack && nvm_op == 3'h2 |-> ##[1:4] (nvm_req && nvm_op == 3'h4)) else $error("no full verify");
endmodule

// file: flash_security_init_control_tb.sv
`timescale 1ns/10ps
// ==========
// Self-checking bench: bus tasks on one side, the array model on the other.
module flash_security_init_control_tb;
  logic clock, nrst, read, write, waitrequest, nvm_req, nvm_ack, nvm_sbe, nvm_dbe, cmd_permitted;
  logic array_read_valid, device_secured, fault_verify;
  logic [5:0] address;
  logic [31:0] writedata, readdata, q;
  logic [3:0] byteenable;
  logic [2:0] nvm_op;
  logic [17:0] nvm_addr, fault_addr;
  logic [15:0] nvm_rdata;
  logic [15:0] slot [5];
  int err_count, checks;
  flash_security_init_control dut (.clock, .nrst, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .nvm_req, .nvm_op, .nvm_addr, .nvm_ack, .nvm_rdata, .nvm_sbe, .nvm_dbe,
    .cmd_permitted, .array_read_valid, .device_secured);
  nvm_array_model arr (.clock, .nrst, .nvm_req, .nvm_op, .nvm_addr, .fault_addr, .fault_verify,
    .nvm_ack, .nvm_rdata, .nvm_sbe, .nvm_dbe);
  // A 100 ns clock.
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // The request stands until the rising edge that sees waitrequest low; read data are taken there.
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clock);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    do begin
      @(posedge clock);
      if (++n > 300) begin
        err_count++;
        finish_test();
      end
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, '0);
    chk(q, 32'(e));
  endtask
  // Only status reads while a command runs: no register write before completion.
  task automatic poll;
    int n = 0;
    do begin
      bus(1'b0, flash_sec_pkg::OFS_STATUS, '0);
      if (++n > 50) begin
        err_count++;
        finish_test();
      end
    end while (q[7] !== 1'b1);
  endtask
  // The first write falls in the load and waits out the stall.
  task automatic do_reset;
    @(posedge clock);
    nrst <= 1'b0;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    bus(1'b1, flash_sec_pkg::OFS_INDEX, 32'h0000_0000);
    poll();
  endtask
  // Loads all slots, sets the index, launches, checks status, clears error flags.
  task automatic run(input logic [2:0] idx, input logic [7:0] exp);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, flash_sec_pkg::OFS_INDEX, 32'(i));
      bus(1'b1, flash_sec_pkg::OFS_COBJ, 32'(slot[i]));
    end
    bus(1'b1, flash_sec_pkg::OFS_INDEX, 32'(idx));
    bus(1'b1, flash_sec_pkg::OFS_STATUS, 32'h0000_0080);
    poll();
    chk(q, 32'(exp));
    bus(1'b1, flash_sec_pkg::OFS_STATUS, 32'h0000_0030);
  endtask
  task automatic t_basic;
    rd(flash_sec_pkg::OFS_OPT, 8'h5A);
    rd(flash_sec_pkg::OFS_SEC, 8'h83);
    chk(32'(device_secured), 32'h1);
    bus(1'b1, flash_sec_pkg::OFS_RSV_A, 32'hFFFF_FFFF);
    rd(flash_sec_pkg::OFS_RSV_A, 8'h00);
    rd(flash_sec_pkg::OFS_RSV_B, 8'h00);
    rd(6'h3C, 8'h00);
    $display("basic test done");
  endtask
  task automatic t_erase;
    slot = '{16'h0A03, 16'h8000, 16'h0000, 16'h0000, 16'h0000};
    run(3'h0, 8'hA0);
    run(3'h1, 8'h80);
    cmd_permitted <= 1'b0;
    run(3'h1, 8'hA0);
    cmd_permitted <= 1'b1;
    slot[1] = 16'h8004;
    run(3'h1, 8'hA0);
    slot = '{16'h0A01, 16'h8000, 16'h0000, 16'h0000, 16'h0000};
    run(3'h1, 8'hA0);
    slot[0] = 16'h0B00;
    fault_verify <= 1'b1;
    run(3'h0, 8'h83);
    fault_verify <= 1'b0;
    chk(32'(device_secured), 32'h1);
    run(3'h0, 8'h80);
    chk(32'(device_secured), 32'h0);
    $display("erase test done");
  endtask
  task automatic t_keys;
    slot = '{16'h0C00, 16'h1111, 16'h2222, 16'h3333, 16'h4445};
    run(3'h4, 8'hA0);
    slot[4] = 16'h4444;
    run(3'h4, 8'hA0);
    do_reset();
    run(3'h4, 8'h80);
    rd(flash_sec_pkg::OFS_SEC, 8'h82);
    chk(32'(device_secured), 32'h0);
    $display("key test done");
  endtask
  task automatic t_fault;
    fault_addr <= flash_sec_pkg::CFG_OPTSEC_ADDR;
    do_reset();
    chk(q, 32'h0000_0083);
    fault_addr <= 18'h0_0000;
    rd(flash_sec_pkg::OFS_OPT, 8'hFF);
    rd(flash_sec_pkg::OFS_SEC, 8'hFF);
    slot = '{16'h0A03, 16'h8000, 16'h0000, 16'h0000, 16'h0000};
    run(3'h1, 8'h90);
    slot[0] = 16'h0B00;
    run(3'h0, 8'h90);
    $display("fault test done");
  endtask
  // Main sequence.
  initial begin
    {nrst, read, write, fault_verify} = 4'h0;
    address = 6'h00;
    writedata = 32'h0000_0000;
    byteenable = 4'hF;
    cmd_permitted = 1'b1;
    fault_addr = 18'h0_0000;
    err_count = 0;
    checks = 0;
    do_reset();
    t_basic();
    t_erase();
    t_keys();
    t_fault();
    finish_test();
  end
endmodule
bind flash_security_init_control flash_sec_assertions chk_u (.clock, .nrst, .read, .write, .waitrequest,
  .nvm_req, .nvm_op, .nvm_addr, .nvm_ack, .array_read_valid, .device_secured);
